// File: rtl/sfpdc_pkg.sv
// constants and state type for the flash power-state command block
// Functional notes
// - partial final byte aborts command, no action
// - B9h enters deep sleep when select bit set
// - deep sleep accepts only ABh, 66h, 99h
// - power-down starts at release, within entry limit
// - command bytes are eight clocks, MSB first
// - sleep commands ignored while operation in progress
// - ABh release after byte exits deep sleep
// - ID follows command plus three dummy bytes
// - ID repeats while select stays asserted
// - ABh in deep sleep exits and gives ID
// - ABh in ultra sleep gives no ID
// - ultra resume resets internally, then reaches standby
// - ultra sleep ignores everything except ABh
// - 79h, or B9h with select clear, enters ultra
// - lock needs keys 4Dh then 67h exactly
package sfpdc_pkg;

   localparam int unsigned CLK_MHZ                   = 100;
   localparam int unsigned DEEP_SLEEP_ENTRY_LIMIT_NS = 3000;
   localparam int unsigned DEEP_SLEEP_EXIT_LIMIT_NS  = 3000;
   localparam int unsigned ULTRA_SLEEP_EXIT_LIMIT_NS = 30000;

   localparam int unsigned ENTRY_RAW = DEEP_SLEEP_ENTRY_LIMIT_NS * CLK_MHZ / 1000;
   localparam int unsigned DEXIT_RAW = DEEP_SLEEP_EXIT_LIMIT_NS * CLK_MHZ / 1000;
   localparam int unsigned UEXIT_RAW = ULTRA_SLEEP_EXIT_LIMIT_NS * CLK_MHZ / 1000;

   localparam int unsigned TMR_W = 12;
   localparam logic [TMR_W-1:0] ENTRY_CYC = TMR_W'((ENTRY_RAW < 1) ? 1 : ENTRY_RAW);
   localparam logic [TMR_W-1:0] DEXIT_CYC = TMR_W'((DEXIT_RAW < 1) ? 1 : DEXIT_RAW);
   localparam logic [TMR_W-1:0] UEXIT_CYC = TMR_W'((UEXIT_RAW < 1) ? 1 : UEXIT_RAW);
   localparam logic [TMR_W-1:0] TMR_ONE   = 12'h001;
   localparam logic [TMR_W-1:0] TMR_ZERO  = 12'h000;

   localparam logic [7:0] CMD_DEEP    = 8'hB9;
   localparam logic [7:0] CMD_ULTRA   = 8'h79;
   localparam logic [7:0] CMD_RESUME  = 8'hAB;
   localparam logic [7:0] CMD_RST_EN  = 8'h66;
   localparam logic [7:0] CMD_RST     = 8'h99;
   localparam logic [7:0] CMD_LOCK    = 8'h6F;
   localparam logic [7:0] LOCK_KEY1   = 8'h4D;
   localparam logic [7:0] LOCK_KEY2   = 8'h67;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;
   localparam logic [7:0] ID_DEFAULT  = 8'h5A;

   localparam logic [5:0] LNK_CMD_LAST = 6'h07;
   localparam logic [5:0] LNK_ID_FIRST = 6'h20;
   localparam logic [5:0] LNK_ID_LAST  = 6'h27;
   localparam logic [5:0] LNK_ONE      = 6'h01;

   localparam logic [2:0] BIT_MOD_LAST = 3'h7;
   localparam logic [2:0] BYTE_CMD     = 3'h1;
   localparam logic [2:0] BYTE_KEY1    = 3'h2;
   localparam logic [2:0] BYTE_KEY2    = 3'h3;
   localparam logic [2:0] BYTE_MAX     = 3'h7;
   localparam logic [2:0] CNT3_ZERO    = 3'h0;
   localparam logic [2:0] CNT3_ONE     = 3'h1;

   typedef enum logic [2:0] {
      ST_STANDBY     = 3'h0,
      ST_ENTER_DEEP  = 3'h1,
      ST_DEEP        = 3'h3,
      ST_EXIT_DEEP   = 3'h2,
      ST_ENTER_ULTRA = 3'h4,
      ST_ULTRA       = 3'h5,
      ST_EXIT_ULTRA  = 3'h7
   } sfpdc_state_e;

endpackage : sfpdc_pkg

// File: rtl/sfpdc_link.sv
// serial-clock side: input shifter, bit events and identifier output
`timescale 1ns/10ps
module sfpdc_link (
   input  wire logic       sck_i,
   input  wire logic       rst_i,
   input  wire logic       cs_n_i,
   input  wire logic       si_i,
   input  wire logic       no_id_i,
   input  wire logic [7:0] id_i,
   output logic            bit_tgl_o,
   output logic [7:0]      shift_o,
   output logic            so_o,
   output logic            so_oe_o
);
   logic       frame_rst;
   logic [5:0] cnt_q;
   logic [7:0] cmd_q;
   logic       noid_meta_q;
   logic       noid_q;
   logic       id_on;

   // counters restart whenever select is high
   assign frame_rst = rst_i | cs_n_i;

   always_ff @(posedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         shift_o   <= sfpdc_pkg::BYTE_ZERO;
         bit_tgl_o <= 1'b0;
      end else begin
         shift_o   <= {shift_o[6:0], si_i};
         bit_tgl_o <= ~bit_tgl_o;
      end
   end

   always_ff @(posedge sck_i or posedge frame_rst) begin
      if (frame_rst) begin
         cnt_q <= 6'h00;
         cmd_q <= sfpdc_pkg::BYTE_ZERO;
      end else begin
         if (cnt_q == sfpdc_pkg::LNK_CMD_LAST) begin
            cmd_q <= {shift_o[6:0], si_i};
         end
         if (cnt_q == sfpdc_pkg::LNK_ID_LAST) begin
            cnt_q <= sfpdc_pkg::LNK_ID_FIRST;
         end else begin
            cnt_q <= cnt_q + sfpdc_pkg::LNK_ONE;
         end
      end
   end

   always_ff @(posedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         noid_meta_q <= 1'b1;
         noid_q      <= 1'b1;
      end else begin
         noid_meta_q <= no_id_i;
         noid_q      <= noid_meta_q;
      end
   end

   assign id_on = (cmd_q == sfpdc_pkg::CMD_RESUME) && !noid_q && (cnt_q >= sfpdc_pkg::LNK_ID_FIRST);

   always_ff @(negedge sck_i or posedge frame_rst) begin
      if (frame_rst) begin
         so_o    <= 1'b0;
         so_oe_o <= 1'b0;
      end else begin
         so_o    <= id_on ? id_i[3'h7 - cnt_q[2:0]] : 1'b0;
         so_oe_o <= id_on;
      end
   end

endmodule : sfpdc_link

// File: rtl/sfpdc_top.sv
// command-level power-state control of the serial flash port
`timescale 1ns/10ps
module sfpdc_top #(
   parameter logic [7:0] DEVICE_ID = sfpdc_pkg::ID_DEFAULT
) (
   input  wire logic       MCLK_I,
   input  wire logic       RST_I,
   input  wire logic       SCK_I,
   input  wire logic       CS_N_I,
   input  wire logic       SI_I,
   input  wire logic       SLEEP_DEPTH_SELECT_I,
   input  wire logic       OP_IN_PROGRESS_FLAG_I,
   output logic            SO_O,
   output logic            SO_OE_O,
   output logic            STANDBY_O,
   output logic            DEEP_SLEEP_O,
   output logic            ULTRA_SLEEP_O,
   output logic            CMD_VALID_O,
   output logic [7:0]      CMD_CODE_O,
   output logic            LOCK_STATUS_O,
   output logic            INTERNAL_RESET_O,
   output logic            FRAME_ABORT_O
);
   // identifier value is arbitrary

   sfpdc_pkg::sfpdc_state_e state_q;
   sfpdc_pkg::sfpdc_state_e state_d;

   logic [sfpdc_pkg::TMR_W-1:0] tmr_q;
   logic [sfpdc_pkg::TMR_W-1:0] tmr_d;

   logic       cs_meta_q;
   logic       cs_sync_q;
   logic       cs_prev_q;
   logic       cs_rise;

   logic       tgl_meta_q;
   logic       tgl_sync_q;
   logic       tgl_prev_q;
   logic       bit_evt;

   logic       link_tgl;
   logic [7:0] link_shift;

   logic [2:0] bit_mod_q;
   logic [2:0] byte_cnt_q;
   logic [7:0] cmd_q;
   logic [7:0] key1_q;
   logic [7:0] key2_q;

   logic       whole;
   logic       is_busy;
   logic       go_deep;
   logic       go_ultra;
   logic       go_exit_deep;
   logic       go_exit_ultra;
   logic       pass_cmd;
   logic       lock_ok;

   logic       no_id_q;

   sfpdc_link u_link (
      .sck_i     (SCK_I),
      .rst_i     (RST_I),
      .cs_n_i    (CS_N_I),
      .si_i      (SI_I),
      .no_id_i   (no_id_q),
      .id_i      (DEVICE_ID),
      .bit_tgl_o (link_tgl),
      .shift_o   (link_shift),
      .so_o      (SO_O),
      .so_oe_o   (SO_OE_O)
   );

   // select pin into core clock
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         cs_meta_q <= 1'b1;
         cs_sync_q <= 1'b1;
         cs_prev_q <= 1'b1;
      end else begin
         cs_meta_q <= CS_N_I;
         cs_sync_q <= cs_meta_q;
         cs_prev_q <= cs_sync_q;
      end
   end

   assign cs_rise = cs_sync_q & ~cs_prev_q;

   // bit toggle from serial clock side
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         tgl_meta_q <= 1'b0;
         tgl_sync_q <= 1'b0;
         tgl_prev_q <= 1'b0;
      end else begin
         tgl_meta_q <= link_tgl;
         tgl_sync_q <= tgl_meta_q;
         tgl_prev_q <= tgl_sync_q;
      end
   end

   assign bit_evt = tgl_sync_q ^ tgl_prev_q;

   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         bit_mod_q  <= sfpdc_pkg::CNT3_ZERO;
         byte_cnt_q <= sfpdc_pkg::CNT3_ZERO;
      end else if (cs_rise) begin
         bit_mod_q  <= sfpdc_pkg::CNT3_ZERO;
         byte_cnt_q <= sfpdc_pkg::CNT3_ZERO;
      end else if (bit_evt) begin
         bit_mod_q <= bit_mod_q + sfpdc_pkg::CNT3_ONE;
         if (bit_mod_q == sfpdc_pkg::BIT_MOD_LAST && byte_cnt_q != sfpdc_pkg::BYTE_MAX) begin
            byte_cnt_q <= byte_cnt_q + sfpdc_pkg::CNT3_ONE;
         end
      end
   end

   // shifter is stable for most of a serial period after its toggle
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         cmd_q  <= sfpdc_pkg::BYTE_ZERO;
         key1_q <= sfpdc_pkg::BYTE_ZERO;
         key2_q <= sfpdc_pkg::BYTE_ZERO;
      end else if (bit_evt && bit_mod_q == sfpdc_pkg::BIT_MOD_LAST) begin
         case (byte_cnt_q)
            sfpdc_pkg::CNT3_ZERO: begin
               cmd_q <= link_shift;
            end
            sfpdc_pkg::BYTE_CMD: begin
               key1_q <= link_shift;
            end
            sfpdc_pkg::BYTE_KEY1: begin
               key2_q <= link_shift;
            end
            default: begin
               key2_q <= key2_q;
            end
         endcase
      end
   end

   assign whole   = (bit_mod_q == sfpdc_pkg::CNT3_ZERO) && (byte_cnt_q != sfpdc_pkg::CNT3_ZERO);
   assign is_busy = OP_IN_PROGRESS_FLAG_I;

   always_comb begin
      go_deep       = 1'b0;
      go_ultra      = 1'b0;
      go_exit_deep  = 1'b0;
      go_exit_ultra = 1'b0;
      pass_cmd      = 1'b0;
      lock_ok       = 1'b0;
      if (cs_rise && whole) begin
         case (state_q)
            sfpdc_pkg::ST_STANDBY: begin
               if (cmd_q == sfpdc_pkg::CMD_DEEP) begin
                  go_deep  = !is_busy && SLEEP_DEPTH_SELECT_I;
                  go_ultra = !is_busy && !SLEEP_DEPTH_SELECT_I;
               end else if (cmd_q == sfpdc_pkg::CMD_ULTRA) begin
                  go_ultra = !is_busy;
               end else if (cmd_q == sfpdc_pkg::CMD_LOCK) begin
                  lock_ok = (byte_cnt_q == sfpdc_pkg::BYTE_KEY2) &&
                            (key1_q == sfpdc_pkg::LOCK_KEY1) &&
                            (key2_q == sfpdc_pkg::LOCK_KEY2);
               end else begin
                  pass_cmd = 1'b1;
               end
            end
            sfpdc_pkg::ST_DEEP: begin
               if (cmd_q == sfpdc_pkg::CMD_RESUME) begin
                  go_exit_deep = 1'b1;
               end else if (cmd_q == sfpdc_pkg::CMD_RST_EN || cmd_q == sfpdc_pkg::CMD_RST) begin
                  pass_cmd = 1'b1;
               end
            end
            sfpdc_pkg::ST_ULTRA: begin
               go_exit_ultra = (cmd_q == sfpdc_pkg::CMD_RESUME);
            end
            default: begin
               pass_cmd = 1'b0;
            end
         endcase
      end
   end

   always_comb begin
      state_d = state_q;
      tmr_d   = tmr_q;
      case (state_q)
         sfpdc_pkg::ST_STANDBY: begin
            if (go_deep) begin
               state_d = sfpdc_pkg::ST_ENTER_DEEP;
               tmr_d   = sfpdc_pkg::ENTRY_CYC;
            end else if (go_ultra) begin
               state_d = sfpdc_pkg::ST_ENTER_ULTRA;
               tmr_d   = sfpdc_pkg::ENTRY_CYC;
            end
         end
         sfpdc_pkg::ST_ENTER_DEEP: begin
            tmr_d = tmr_q - sfpdc_pkg::TMR_ONE;
            if (tmr_q == sfpdc_pkg::TMR_ONE) begin
               state_d = sfpdc_pkg::ST_DEEP;
            end
         end
         sfpdc_pkg::ST_DEEP: begin
            if (go_exit_deep) begin
               state_d = sfpdc_pkg::ST_EXIT_DEEP;
               tmr_d   = sfpdc_pkg::DEXIT_CYC;
            end
         end
         sfpdc_pkg::ST_EXIT_DEEP: begin
            tmr_d = tmr_q - sfpdc_pkg::TMR_ONE;
            if (tmr_q == sfpdc_pkg::TMR_ONE) begin
               state_d = sfpdc_pkg::ST_STANDBY;
            end
         end
         sfpdc_pkg::ST_ENTER_ULTRA: begin
            tmr_d = tmr_q - sfpdc_pkg::TMR_ONE;
            if (tmr_q == sfpdc_pkg::TMR_ONE) begin
               state_d = sfpdc_pkg::ST_ULTRA;
            end
         end
         sfpdc_pkg::ST_ULTRA: begin
            if (go_exit_ultra) begin
               state_d = sfpdc_pkg::ST_EXIT_ULTRA;
               tmr_d   = sfpdc_pkg::UEXIT_CYC;
            end
         end
         sfpdc_pkg::ST_EXIT_ULTRA: begin
            tmr_d = tmr_q - sfpdc_pkg::TMR_ONE;
            if (tmr_q == sfpdc_pkg::TMR_ONE) begin
               state_d = sfpdc_pkg::ST_STANDBY;
            end
         end
         default: begin
            state_d = sfpdc_pkg::ST_STANDBY;
            tmr_d   = sfpdc_pkg::TMR_ZERO;
         end
      endcase
   end

   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_q <= sfpdc_pkg::ST_STANDBY;
         tmr_q   <= sfpdc_pkg::TMR_ZERO;
      end else begin
         state_q <= state_d;
         tmr_q   <= tmr_d;
      end
   end

   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         no_id_q <= 1'b0;
      end else begin
         no_id_q <= (state_d != sfpdc_pkg::ST_STANDBY) && (state_d != sfpdc_pkg::ST_DEEP) &&
                    (state_d != sfpdc_pkg::ST_EXIT_DEEP) && (state_d != sfpdc_pkg::ST_ENTER_DEEP);
      end
   end

   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         STANDBY_O     <= 1'b1;
         DEEP_SLEEP_O  <= 1'b0;
         ULTRA_SLEEP_O <= 1'b0;
      end else begin
         STANDBY_O     <= (state_d == sfpdc_pkg::ST_STANDBY);
         DEEP_SLEEP_O  <= (state_d == sfpdc_pkg::ST_DEEP);
         ULTRA_SLEEP_O <= (state_d == sfpdc_pkg::ST_ULTRA);
      end
   end

   // one-cycle event outputs; CMD_CODE_O holds the last passed command code
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         CMD_VALID_O      <= 1'b0;
         CMD_CODE_O       <= sfpdc_pkg::BYTE_ZERO;
         LOCK_STATUS_O    <= 1'b0;
         INTERNAL_RESET_O <= 1'b0;
         FRAME_ABORT_O    <= 1'b0;
      end else begin
         CMD_VALID_O      <= pass_cmd;
         LOCK_STATUS_O    <= lock_ok;
         INTERNAL_RESET_O <= go_exit_ultra;
         FRAME_ABORT_O    <= cs_rise && !whole && (bit_mod_q != sfpdc_pkg::CNT3_ZERO);
         if (pass_cmd) begin
            CMD_CODE_O <= cmd_q;
         end
      end
   end

endmodule : sfpdc_top

// File: tb/sfpdc_monitor.sv
// assertion checker on the power-state block ports
`timescale 1ns/10ps
module sfpdc_monitor (
   input wire logic       MCLK_I,
   input wire logic       RST_I,
   input wire logic       CS_N_I,
   input wire logic       SLEEP_DEPTH_SELECT_I,
   input wire logic       OP_IN_PROGRESS_FLAG_I,
   input wire logic       SO_OE_O,
   input wire logic       STANDBY_O,
   input wire logic       DEEP_SLEEP_O,
   input wire logic       ULTRA_SLEEP_O,
   input wire logic       CMD_VALID_O,
   input wire logic [7:0] CMD_CODE_O,
   input wire logic       LOCK_STATUS_O,
   input wire logic       INTERNAL_RESET_O,
   input wire logic       FRAME_ABORT_O
);
   localparam int E = sfpdc_pkg::ENTRY_CYC;
   localparam int D = sfpdc_pkg::DEXIT_CYC;
   localparam int U = sfpdc_pkg::UEXIT_CYC;
   logic [12:0] gap_q;
   logic        was_ultra_q;
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (RST_I);
   // idle cycles between power states
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         gap_q       <= 13'h0000;
         was_ultra_q <= 1'b0;
      end else begin
         gap_q <= (STANDBY_O | DEEP_SLEEP_O | ULTRA_SLEEP_O) ? 13'h0000 : gap_q + 13'h0001;
         if (ULTRA_SLEEP_O) was_ultra_q <= 1'b1;
         else if (DEEP_SLEEP_O) was_ultra_q <= 1'b0;
      end
   end
   a_abort_no_action: assert property (FRAME_ABORT_O |-> !(CMD_VALID_O || LOCK_STATUS_O || INTERNAL_RESET_O)
      && $stable({STANDBY_O, DEEP_SLEEP_O, ULTRA_SLEEP_O})) else $error("abort with side effect");
   a_deep_needs_select: assert property ($rose(DEEP_SLEEP_O) |-> SLEEP_DEPTH_SELECT_I)
      else $error("deep sleep without select");
   a_deep_entry_time: assert property ($rose(DEEP_SLEEP_O) |-> gap_q inside {[E-6:E+1]})
      else $error("deep entry time wrong");
   a_start_at_release: assert property ($fell(STANDBY_O) |-> CS_N_I && $past(CS_N_I, 2))
      else $error("power change inside frame");
   a_busy_blocks_sleep: assert property ($fell(STANDBY_O) |-> !OP_IN_PROGRESS_FLAG_I)
      else $error("sleep entered while busy");
   a_deep_exit_time: assert property ($rose(STANDBY_O) && !was_ultra_q |-> gap_q inside {[D-6:D+1]})
      else $error("deep exit time wrong");
   a_ultra_exit_time: assert property ($rose(STANDBY_O) && was_ultra_q |-> gap_q inside {[U-6:U+1]})
      else $error("ultra exit time wrong");
   a_ultra_reset_src: assert property (INTERNAL_RESET_O |-> $past(ULTRA_SLEEP_O) && !ULTRA_SLEEP_O)
      else $error("internal reset outside ultra resume");
   a_no_id_ultra: assert property (SO_OE_O |-> !ULTRA_SLEEP_O && !CS_N_I)
      else $error("output driven in ultra or idle");
   a_deep_cmd_gate: assert property (CMD_VALID_O && DEEP_SLEEP_O |-> CMD_CODE_O inside {8'h66, 8'h99})
      else $error("command passed in deep sleep");
   a_ultra_cmd_gate: assert property (ULTRA_SLEEP_O |-> !(CMD_VALID_O || LOCK_STATUS_O))
      else $error("command passed in ultra sleep");
   a_lock_standby: assert property (LOCK_STATUS_O |-> STANDBY_O)
      else $error("lock outside standby");
   c_deep: cover property ($rose(DEEP_SLEEP_O));
   c_ureset: cover property (INTERNAL_RESET_O);
   c_lock: cover property (LOCK_STATUS_O);
   c_abort: cover property (FRAME_ABORT_O);
endmodule : sfpdc_monitor

// File: tb/sfpdc_host.sv
// behavioural spi host driving select, clock and input data
`timescale 1ns/10ps
module sfpdc_host (
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      si_o,
   input  wire logic so_i,
   input  wire logic so_oe_i
);
   initial begin
      cs_n_o = 1'b1;
      sck_o  = 1'b0;
      si_o   = 1'b0;
   end
   task automatic xfer(input logic [47:0] d, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      #3 cs_n_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         si_o = d[47-i];
         #20 sck_o = 1'b1;
         if (i >= 32) rd = {rd[14:0], so_i & so_oe_i};
         #40 sck_o = 1'b0;
         #20;
      end
      #20 cs_n_o = 1'b1;
      si_o = ~si_o;
      #200;
   endtask : xfer
endmodule : sfpdc_host

// File: tb/testbench.sv
// self-checking bench for the power-state block
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
   localparam logic [7:0] ID = 8'hC3; // arbitrary identifier
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        dsel = 1'b1;
   logic        busy = 1'b0;
   logic [2:0]  st_q = 3'h4;
   logic [7:0]  c;
   logic [15:0] rd;
   logic [11:0] q[$];
   int          num_errors = 0;
   int          checks = 0;
   int          seed = 15;
   wire         sck, cs_n, si, so, oe, stby, deep, ultra, cv, lock, irst, abrt;
   wire  [7:0]  code;
   always #5 mclk = ~mclk;
   sfpdc_host host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so), .so_oe_i(oe));
   sfpdc_top #(.DEVICE_ID(ID)) DUT (.MCLK_I(mclk), .RST_I(rst), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si),
      .SLEEP_DEPTH_SELECT_I(dsel), .OP_IN_PROGRESS_FLAG_I(busy), .SO_O(so), .SO_OE_O(oe), .STANDBY_O(stby),
      .DEEP_SLEEP_O(deep), .ULTRA_SLEEP_O(ultra), .CMD_VALID_O(cv), .CMD_CODE_O(code), .LOCK_STATUS_O(lock),
      .INTERNAL_RESET_O(irst), .FRAME_ABORT_O(abrt));
   task automatic report_and_stop();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   task automatic seen(input logic [11:0] e);
      logic [11:0] x;
      x = (q.size() != 0) ? q.pop_front() : 12'hFFF;
      `CHK(e, x)
   endtask : seen
   // results in fixed order: pulses, then state
   // sampled mid-cycle so registered outputs have settled
   always @(negedge mclk) begin
      if (!rst) begin
         if (cv === 1'b1) seen({4'h1, code});
         if (lock === 1'b1) seen(12'h200);
         if (irst === 1'b1) seen(12'h300);
         if (abrt === 1'b1) seen(12'h400);
         if ({stby, deep, ultra} !== st_q) seen({9'h0A0, stby, deep, ultra});
      end
      st_q = {stby, deep, ultra};
   end
   task automatic run(input logic [47:0] d, input int n);
      host.xfer(d, n, rd);
      for (int i = 0; i < 4000 && q.size() != 0; i++) @(posedge mclk);
      repeat (20) @(posedge mclk);
      if (q.size() != 0) begin
         `CHK(12'h000, q[0])
         q = {};
      end
   endtask : run
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      `CHK({stby, deep, ultra, cv, oe}, 5'h10)
      for (int k = 0; k < 4; k++) begin
         c = 8'($random(seed));
         if (c inside {8'hB9, 8'h79, 8'h6F}) c = 8'h03;
         q = {{4'h1, c}};
         run({c, 40'($random(seed))}, 8 * (k + 1));
      end
      q = {12'h400};
      run(48'hAB0000000000, 5);
      q = {12'h400};
      run(48'h6F4D67000000, 23);
      q = {12'h200};
      run(48'h6F4D67000000, 24);
      run(48'h6F674D000000, 24);
      busy <= 1'b1;
      run(48'hB90000000000, 8);
      run(48'h790000000000, 8);
      busy <= 1'b0;
      q = {12'h500, 12'h502};
      run(48'hB90000000000, 8);
      for (int k = 1; k < 3; k++) begin
         c = 8'($random(seed));
         if (c inside {8'hAB, 8'h66, 8'h99}) c = 8'h05;
         run({c, 40'($random(seed))}, 16 * k);
      end
      q = {12'h166};
      run(48'h660000000000, 8);
      q = {12'h199};
      run(48'h990000000000, 8);
      q = {12'h500, 12'h504};
      run({8'hAB, 24'($random(seed)), 16'h0000}, 48);
      `CHK(rd, {ID, ID})
      q = {12'h1AB};
      run(48'hAB0000000000, 48);
      `CHK(rd, {ID, ID})
      q = {12'h500, 12'h502};
      run(48'hB90000000000, 8);
      q = {12'h500, 12'h504};
      run(48'hAB0000000000, 8);
      q = {12'h500, 12'h501};
      run(48'h790000000000, 8);
      run(48'h660000000000, 8);
      q = {12'h300, 12'h500, 12'h504};
      run(48'hAB0000000000, 48);
      `CHK(rd, 16'h0000)
      dsel <= 1'b0;
      q = {12'h500, 12'h501};
      run(48'hB90000000000, 8);
      q = {12'h300, 12'h500, 12'h504};
      run(48'hAB0000000000, 8);
      report_and_stop();
   end
   initial begin
      #900000;
      num_errors++;
      report_and_stop();
   end
endmodule : testbench
bind sfpdc_top sfpdc_monitor MON (.MCLK_I(MCLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I),
   .SLEEP_DEPTH_SELECT_I(SLEEP_DEPTH_SELECT_I), .OP_IN_PROGRESS_FLAG_I(OP_IN_PROGRESS_FLAG_I),
   .SO_OE_O(SO_OE_O), .STANDBY_O(STANDBY_O), .DEEP_SLEEP_O(DEEP_SLEEP_O), .ULTRA_SLEEP_O(ULTRA_SLEEP_O),
   .CMD_VALID_O(CMD_VALID_O), .CMD_CODE_O(CMD_CODE_O), .LOCK_STATUS_O(LOCK_STATUS_O),
   .INTERNAL_RESET_O(INTERNAL_RESET_O), .FRAME_ABORT_O(FRAME_ABORT_O));
